// ### rtl/ccpu_pkg.sv
// Constants shared by the capture/compare/PWM unit
package ccpu_pkg;
  // Register indices; byte address is four times the index
  localparam int unsigned CCPU_ADDR_W = 10;
  localparam logic [7:0] CCPU_IDX_PIN_DATA = 8'h07;
  localparam logic [7:0] CCPU_IDX_IRQ_FLAGS = 8'h0C;
  localparam logic [7:0] CCPU_IDX_VALUE_LOW = 8'h15;
  localparam logic [7:0] CCPU_IDX_VALUE_HIGH = 8'h16;
  localparam logic [7:0] CCPU_IDX_CONTROL = 8'h17;
  localparam logic [7:0] CCPU_IDX_PIN_DIR = 8'h87;
  localparam logic [7:0] CCPU_IDX_IRQ_ENABLES = 8'h8C;
  // Field positions
  localparam int unsigned CCPU_PIN_BIT = 2;
  localparam int unsigned CCPU_FLAG_BIT = 2;
  localparam int unsigned CCPU_DUTY_LSB = 4;
  localparam int unsigned CCPU_CTRL_W = 6;
  // Mode field codes
  localparam logic [3:0] CCPU_MODE_OFF = 4'h0;
  localparam logic [1:0] CCPU_GRP_CAPTURE = 2'h1;
  localparam logic [1:0] CCPU_GRP_COMPARE = 2'h2;
  localparam logic [1:0] CCPU_GRP_PWM = 2'h3;
  localparam logic [1:0] CCPU_CAP_FALL = 2'h0;
  localparam logic [1:0] CCPU_CAP_RISE = 2'h1;
  localparam logic [1:0] CCPU_CAP_RISE4 = 2'h2;
  localparam logic [1:0] CCPU_CAP_RISE16 = 2'h3;
  localparam logic [1:0] CCPU_CMP_SET = 2'h0;
  localparam logic [1:0] CCPU_CMP_CLEAR = 2'h1;
  localparam logic [1:0] CCPU_CMP_SWINT = 2'h2;
  localparam logic [1:0] CCPU_CMP_TRIGGER = 2'h3;
  // Prescaler terminal counts
  localparam logic [3:0] CCPU_PRE4_LAST = 4'h3;
  localparam logic [3:0] CCPU_PRE16_LAST = 4'hF;
  // Reset values
  localparam logic [CCPU_CTRL_W-1:0] CCPU_CTRL_RST = 6'h00;
  localparam logic [7:0] CCPU_VALUE_RST = 8'h00;
  localparam logic CCPU_DIR_RST = 1'b1;
  localparam logic CCPU_PIN_DATA_RST = 1'b0;
  localparam logic CCPU_FLAG_RST = 1'b0;
  localparam logic CCPU_ENABLE_RST = 1'b0;
  localparam logic [31:0] CCPU_RDATA_RST = 32'h0000_0000;
endpackage : ccpu_pkg

// ### rtl/ccpu_capture_event.sv
// Pin synchroniser, edge detector and capture prescaler
`timescale 1ns/1ps
`default_nettype none
module ccpu_capture_event
  import ccpu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic pin_async,
  input wire logic capture_en,
  input wire logic [1:0] edge_sel,
  output logic pin_level,
  output logic capture_evt
);
  logic sync1;
  logic sync2;
  logic prev;
  logic [3:0] pre_count;
  logic rise;
  logic fall;
  logic [3:0] last;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      prev <= 1'b0;
    end else if (ce) begin
      sync1 <= pin_async;
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  assign pin_level = sync2;
  assign rise = sync2 & ~prev;
  assign fall = ~sync2 & prev;
  assign last = (edge_sel == CCPU_CAP_RISE16) ? CCPU_PRE16_LAST : CCPU_PRE4_LAST;

  // Counter held clear outside capture mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_count <= 4'h0;
    end else if (ce) begin
      if (!capture_en) begin
        pre_count <= 4'h0;
      end else if (rise && edge_sel[1]) begin
        pre_count <= (pre_count >= last) ? 4'h0 : pre_count + 4'h1;
      end
    end
  end

  always_comb begin
    capture_evt = 1'b0;
    if (capture_en && ce) begin
      case (edge_sel)
        CCPU_CAP_FALL: capture_evt = fall;
        CCPU_CAP_RISE: capture_evt = rise;
        default: capture_evt = rise && (pre_count >= last);
      endcase
    end
  end
endmodule : ccpu_capture_event
`default_nettype wire

// ### rtl/ccpu_unit.sv
// Capture/compare/PWM unit with APB register access
//
// Functional notes
// - 16-bit value as low and high bytes
// - timer one for capture/compare, timer two PWM
// - mode 0000 turns unit off, resets state
// - codes 0100-0111 select capture edge prescale
// - codes 1000-1011 select compare actions, flag set
// - upper mode bits both one select PWM
// - control bits 5:4 are duty LSBs
// - capture copies timer one count
// - capture sets flag, only software clears
// - new capture overwrites unread value
// - output pin data can cause capture
// - mode change may raise spurious flag
// - prescaler cleared outside capture mode
// - prescale switch keeps counter, may interrupt
// - compare every cycle, act on pin, flag
// - control write of zero clears output latch
// - trigger match resets timer one count
// - trigger starts conversion when converter enabled
// - trigger does not set timer one overflow
// - PWM output with 10-bit duty
// - period end clears, sets pin unless duty is zero, latches duty
// - duty match clears pin, over-period never
// - high byte read-only in PWM, double buffered
`timescale 1ns/1ps
`default_nettype none
module ccpu_unit
  import ccpu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [CCPU_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] timer_one_count,
  input wire logic [7:0] timer_two_count,
  input wire logic [7:0] timer_two_period,
  input wire logic timer_two_tick,
  input wire logic [1:0] pwm_sub_bits,
  input wire logic adc_enabled,
  input wire logic unit_pin_in,
  output logic unit_pin_out,
  output logic unit_pin_oe_n,
  output logic timer_one_reset,
  output logic adc_start,
  output logic unit_irq_flag,
  output logic unit_irq_enable
);
  logic [7:0] idx;
  logic addr_hit;
  logic wr_en;
  logic rd_setup;
  logic wr_ctrl;
  logic [7:0] value_low;
  logic [7:0] value_high;
  logic [CCPU_CTRL_W-1:0] control;
  logic pin_dir_bit;
  logic pin_data_bit;
  logic out_latch;
  logic [1:0] duty_latch;
  logic match_q;
  logic [3:0] mode;
  logic is_off;
  logic is_capture;
  logic is_compare;
  logic is_pwm;
  logic pin_level;
  logic capture_evt;
  logic cmp_hit;
  logic cmp_evt;
  logic period_end;
  logic duty_match;
  logic [9:0] next_duty;
  logic [31:0] next_rdata;

  // Bus decode
  assign idx = paddr[CCPU_ADDR_W-1:2];
  assign pready = ce;
  assign wr_en = psel & penable & pwrite & ce;
  assign rd_setup = psel & ~penable & ~pwrite & ce;
  assign wr_ctrl = wr_en && (idx == CCPU_IDX_CONTROL);

  always_comb begin
    case (idx)
      CCPU_IDX_PIN_DATA,
      CCPU_IDX_IRQ_FLAGS,
      CCPU_IDX_VALUE_LOW,
      CCPU_IDX_VALUE_HIGH,
      CCPU_IDX_CONTROL,
      CCPU_IDX_PIN_DIR,
      CCPU_IDX_IRQ_ENABLES: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  assign pslverr = psel & penable & ~addr_hit;

  // Mode decode
  assign mode = control[3:0];
  assign is_off = (mode == CCPU_MODE_OFF);
  assign is_capture = (mode[3:2] == CCPU_GRP_CAPTURE);
  assign is_compare = (mode[3:2] == CCPU_GRP_COMPARE);
  assign is_pwm = (mode[3:2] == CCPU_GRP_PWM);

  ccpu_capture_event u_event (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .pin_async(unit_pin_in),
    .capture_en(is_capture),
    .edge_sel(mode[1:0]),
    .pin_level(pin_level),
    .capture_evt(capture_evt)
  );

  // Compare against timer one, one event per match
  assign cmp_hit = is_compare && ({value_high, value_low} == timer_one_count);
  assign cmp_evt = cmp_hit & ~match_q & ce;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_q <= 1'b0;
    end else if (ce) begin
      match_q <= cmp_hit;
    end
  end

  // PWM period boundary and duty compare on timer two
  assign period_end = is_pwm && timer_two_tick && (timer_two_count == timer_two_period);
  assign duty_match = is_pwm && ({value_high, duty_latch} == {timer_two_count, pwm_sub_bits});
  assign next_duty = {value_low, control[CCPU_DUTY_LSB+1:CCPU_DUTY_LSB]};

  // Value low byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_low <= CCPU_VALUE_RST;
    end else if (ce) begin
      if (capture_evt) begin
        value_low <= timer_one_count[7:0];
      end else if (wr_en && idx == CCPU_IDX_VALUE_LOW) begin
        value_low <= pwdata[7:0];
      end
    end
  end

  // Value high byte, duty buffer in PWM mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_high <= CCPU_VALUE_RST;
    end else if (ce) begin
      if (capture_evt) begin
        value_high <= timer_one_count[15:8];
      end else if (period_end) begin
        value_high <= value_low;
      end else if (wr_en && idx == CCPU_IDX_VALUE_HIGH && !is_pwm) begin
        value_high <= pwdata[7:0];
      end
    end
  end

  // Two-bit duty latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_latch <= 2'h0;
    end else if (ce) begin
      if (is_off) begin
        duty_latch <= 2'h0;
      end else if (period_end) begin
        duty_latch <= control[CCPU_DUTY_LSB+1:CCPU_DUTY_LSB];
      end
    end
  end

  // Control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control <= CCPU_CTRL_RST;
    end else if (wr_ctrl) begin
      control <= pwdata[CCPU_CTRL_W-1:0];
    end
  end

  // Pin direction and pin data latches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_dir_bit <= CCPU_DIR_RST;
    end else if (wr_en && idx == CCPU_IDX_PIN_DIR) begin
      pin_dir_bit <= pwdata[CCPU_PIN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_data_bit <= CCPU_PIN_DATA_RST;
    end else if (wr_en && idx == CCPU_IDX_PIN_DATA) begin
      pin_data_bit <= pwdata[CCPU_PIN_BIT];
    end
  end

  // Compare and PWM output latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_latch <= 1'b0;
    end else if (ce) begin
      if (is_off) begin
        out_latch <= 1'b0;
      end else if (cmp_evt && mode[1:0] == CCPU_CMP_SET) begin
        out_latch <= 1'b1;
      end else if (cmp_evt && mode[1:0] == CCPU_CMP_CLEAR) begin
        out_latch <= 1'b0;
      end else if (period_end) begin
        out_latch <= (next_duty != 10'h000);
      end else if (duty_match) begin
        out_latch <= 1'b0;
      end
    end
  end

  // Pin drive: direction bit low drives the pin
  assign unit_pin_oe_n = pin_dir_bit;
  assign unit_pin_out = mode[3] ? out_latch : pin_data_bit;

  // Special event trigger; no timer one overflow flag here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_one_reset <= 1'b0;
      adc_start <= 1'b0;
    end else if (ce) begin
      timer_one_reset <= cmp_evt && mode[1:0] == CCPU_CMP_TRIGGER;
      adc_start <= cmp_evt && mode[1:0] == CCPU_CMP_TRIGGER && adc_enabled;
    end
  end

  // Unit flag: a hardware set wins over a software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_irq_flag <= CCPU_FLAG_RST;
    end else if (ce) begin
      if (capture_evt || cmp_evt) begin
        unit_irq_flag <= 1'b1;
      end else if (wr_en && idx == CCPU_IDX_IRQ_FLAGS) begin
        unit_irq_flag <= pwdata[CCPU_FLAG_BIT];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_irq_enable <= CCPU_ENABLE_RST;
    end else if (wr_en && idx == CCPU_IDX_IRQ_ENABLES) begin
      unit_irq_enable <= pwdata[CCPU_FLAG_BIT];
    end
  end

  // Read data, sampled in the setup cycle
  always_comb begin
    next_rdata = CCPU_RDATA_RST;
    case (idx)
      CCPU_IDX_PIN_DATA: next_rdata[CCPU_PIN_BIT] = pin_dir_bit ? pin_level : pin_data_bit;
      CCPU_IDX_IRQ_FLAGS: next_rdata[CCPU_FLAG_BIT] = unit_irq_flag;
      CCPU_IDX_VALUE_LOW: next_rdata[7:0] = value_low;
      CCPU_IDX_VALUE_HIGH: next_rdata[7:0] = value_high;
      CCPU_IDX_CONTROL: next_rdata[CCPU_CTRL_W-1:0] = control;
      CCPU_IDX_PIN_DIR: next_rdata[CCPU_PIN_BIT] = pin_dir_bit;
      CCPU_IDX_IRQ_ENABLES: next_rdata[CCPU_FLAG_BIT] = unit_irq_enable;
      default: next_rdata = CCPU_RDATA_RST;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= CCPU_RDATA_RST;
    end else if (rd_setup) begin
      prdata <= next_rdata;
    end
  end
endmodule : ccpu_unit
`default_nettype wire

// ### tb/ccpu_checker.sv
// Port-level assertions for the capture/compare/PWM unit
`timescale 1ns/1ps
`default_nettype none
module ccpu_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic adc_enabled,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic unit_pin_oe_n,
  input wire logic timer_one_reset,
  input wire logic adc_start,
  input wire logic unit_irq_flag
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic wr;
  assign wr = psel && penable && pwrite && ce;
  chk_ready_follows_ce: assert property (pready == ce)
    else $error("pready differs from ce");
  chk_adc_needs_trig: assert property (adc_start |-> timer_one_reset && adc_enabled)
    else $error("conversion start without enabled trigger");
  chk_trig_starts_adc: assert property (timer_one_reset && adc_enabled |-> adc_start)
    else $error("trigger missed conversion start");
  chk_trig_one_pulse: assert property (timer_one_reset |=> !timer_one_reset)
    else $error("timer reset longer than one cycle");
  chk_flag_sticky: assert property (unit_irq_flag && !wr |=> unit_irq_flag)
    else $error("flag cleared without software write");
  chk_err_in_access: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  chk_freeze_flag: assert property (!ce |=> $stable(unit_irq_flag))
    else $error("flag moved while clock enable low");
  chk_dir_by_write: assert property (!wr |=> $stable(unit_pin_oe_n))
    else $error("pin direction moved without write");
  cover property (timer_one_reset && adc_start);
  cover property (pslverr);
  cover property ($rose(unit_irq_flag));
endmodule : ccpu_checker
bind ccpu_unit ccpu_checker i_chk (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .adc_enabled,
  .pready, .pslverr, .unit_pin_oe_n, .timer_one_reset, .adc_start, .unit_irq_flag);
`default_nettype wire

// ### tb/ccpu_pin_source.sv
// External pin model resolving source and unit drive
`timescale 1ns/1ps
`default_nettype none
module ccpu_pin_source (
  input wire logic ext_level,
  input wire logic unit_pin_out,
  input wire logic unit_pin_oe_n,
  output logic unit_pin_in
);
  // Unit drives when enable low, else the source
  assign unit_pin_in = unit_pin_oe_n ? ext_level : unit_pin_out;
endmodule : ccpu_pin_source
`default_nettype wire

// ### tb/ccpu_unit_tb_top.sv
// Self-checking testbench for the capture/compare/PWM unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin miscompares++; \
  $display("mismatch %s exp %h got %h", nm, ex, got); end end
module ccpu_unit_tb_top import ccpu_pkg::*; ();
  logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic timer_two_tick = 1'b0, adc_enabled = 1'b0, ext = 1'b0, e;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [15:0] timer_one_count = 16'h0000;
  logic [7:0] timer_two_count = 8'h00, timer_two_period = 8'h03;
  logic [1:0] pwm_sub_bits = 2'h0;
  logic pready, pslverr, unit_pin_in, unit_pin_out, unit_pin_oe_n;
  logic timer_one_reset, adc_start, unit_irq_flag, unit_irq_enable;
  int miscompares = 0, samples_checked = 0, n_rst = 0, n_adc = 0;
  ccpu_unit i_dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .timer_one_count, .timer_two_count, .timer_two_period, .timer_two_tick,
    .pwm_sub_bits, .adc_enabled, .unit_pin_in, .unit_pin_out, .unit_pin_oe_n, .timer_one_reset,
    .adc_start, .unit_irq_flag, .unit_irq_enable);
  ccpu_pin_source i_pin (.ext_level(ext), .unit_pin_out, .unit_pin_oe_n, .unit_pin_in);
  initial forever #5 pclk = ~pclk;
  // Timer two: one increment every four cycles
  always @(posedge pclk) begin
    pwm_sub_bits <= pwm_sub_bits + 2'h1;
    timer_two_tick <= pwm_sub_bits == 2'h2;
    if (timer_two_tick) timer_two_count <= (timer_two_count == timer_two_period) ? 8'h00 : timer_two_count + 8'h01;
    n_rst <= n_rst + timer_one_reset;
    n_adc <= n_adc + adc_start;
  end
  task results();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  task apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
    // Let the written state settle before any caller looks at it
    cyc(1);
  endtask : wr
  task rd(input logic [7:0] idx, input logic [7:0] ex, input string nm);
    apb(1'b0, idx, 8'h00);
    `CHK(nm, {24'h000000, ex}, r)
  endtask : rd
  task t_regs();
    rd(CCPU_IDX_CONTROL, 8'h00, "ctrl_rst");
    rd(CCPU_IDX_IRQ_FLAGS, 8'h00, "flags_rst");
    rd(CCPU_IDX_IRQ_ENABLES, 8'h00, "en_rst");
    rd(CCPU_IDX_PIN_DIR, 8'h04, "dir_rst");
    wr(CCPU_IDX_VALUE_LOW, 8'hA5);
    wr(CCPU_IDX_VALUE_HIGH, 8'h5A);
    rd(CCPU_IDX_VALUE_LOW, 8'hA5, "val_low");
    rd(CCPU_IDX_VALUE_HIGH, 8'h5A, "val_high");
    wr(CCPU_IDX_CONTROL, 8'hF4);
    rd(CCPU_IDX_CONTROL, 8'h34, "ctrl_top");
    wr(CCPU_IDX_IRQ_ENABLES, 8'h04);
    `CHK("irq_en", 1'b1, unit_irq_enable)
    wr(CCPU_IDX_IRQ_FLAGS, 8'h04);
    ce <= 1'b0;
    cyc(3);
    ce <= 1'b1;
    `CHK("flag_sw", 1'b1, unit_irq_flag)
    apb(1'b0, 8'h40, 8'h00);
    `CHK("unmapped_err", 1'b1, e)
    `CHK("unmapped_data", 32'h0, r)
  endtask : t_regs
  task cap(input logic [3:0] code, input int n);
    wr(CCPU_IDX_CONTROL, 8'h00);
    wr(CCPU_IDX_CONTROL, {4'h0, code});
    wr(CCPU_IDX_IRQ_FLAGS, 8'h00);
    timer_one_count <= 16'h0F0F;
    repeat (n) begin
      if (code[1]) `CHK("cap_early", 1'b0, unit_irq_flag)
      if (n == 1) timer_one_count <= {12'hC00, code};
      ext <= 1'b1;
      cyc(6);
      ext <= 1'b0;
      cyc(6);
      n--;
    end
    `CHK("cap_flag", 1'b1, unit_irq_flag)
    rd(CCPU_IDX_VALUE_LOW, {4'h0, code}, "cap_low");
    rd(CCPU_IDX_VALUE_HIGH, 8'hC0, "cap_high");
  endtask : cap
  task t_capture();
    cap(4'h4, 1);
    cap(4'h5, 2);
    cap(4'h6, 4);
    cap(4'h7, 16);
  endtask : t_capture
  task t_pin_cap();
    wr(CCPU_IDX_CONTROL, 8'h00);
    wr(CCPU_IDX_CONTROL, 8'h05);
    wr(CCPU_IDX_PIN_DIR, 8'h00);
    `CHK("oe_n", 1'b0, unit_pin_oe_n)
    wr(CCPU_IDX_IRQ_FLAGS, 8'h00);
    timer_one_count <= 16'h2211;
    wr(CCPU_IDX_PIN_DATA, 8'h04);
    cyc(5);
    rd(CCPU_IDX_VALUE_LOW, 8'h11, "pin_cap");
    wr(CCPU_IDX_PIN_DATA, 8'h00);
  endtask : t_pin_cap
  task cmp(input logic [3:0] code, input logic ex);
    timer_one_count <= 16'h0000;
    wr(CCPU_IDX_CONTROL, {4'h0, code});
    wr(CCPU_IDX_IRQ_FLAGS, 8'h00);
    timer_one_count <= 16'h0100;
    cyc(4);
    `CHK("cmp_flag", 1'b1, unit_irq_flag)
    `CHK("cmp_pin", ex, unit_pin_out)
  endtask : cmp
  task t_compare();
    wr(CCPU_IDX_VALUE_LOW, 8'h00);
    wr(CCPU_IDX_VALUE_HIGH, 8'h01);
    cmp(4'h8, 1'b1);
    cmp(4'h9, 1'b0);
    cmp(4'h8, 1'b1);
    wr(CCPU_IDX_CONTROL, 8'h00);
    cmp(4'hA, 1'b0);
    adc_enabled <= 1'b1;
    cmp(4'hB, 1'b0);
    adc_enabled <= 1'b0;
    cmp(4'hB, 1'b0);
    `CHK("trig_count", 2, n_rst)
    `CHK("adc_count", 1, n_adc)
  endtask : t_compare
  task pwm(input logic [7:0] lo, input logic [3:0] code, input int ex);
    int h;
    h = 0;
    wr(CCPU_IDX_VALUE_LOW, lo);
    wr(CCPU_IDX_CONTROL, {2'b00, lo[1:0], code});
    cyc(40);
    rd(CCPU_IDX_VALUE_HIGH, lo, "pwm_latch");
    repeat (64) begin @(posedge pclk); h += (unit_pin_out === 1'b1); end
    if (ex >= 0) `CHK("pwm_high", ex, h)
    else `CHK("pwm_mid", 1'b1, h > 0 && h < 64)
  endtask : pwm
  task t_pwm();
    pwm(8'h00, 4'hC, 0);
    pwm(8'hFF, 4'hD, 64);
    pwm(8'h01, 4'hF, -1);
    wr(CCPU_IDX_VALUE_HIGH, 8'h55);
    rd(CCPU_IDX_VALUE_HIGH, 8'h01, "pwm_ro");
  endtask : t_pwm
  initial begin
    #100us;
    miscompares++;
    results();
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_capture();
    t_pin_cap();
    t_compare();
    t_pwm();
    results();
  end
endmodule : ccpu_unit_tb_top
`default_nettype wire
